// [core/ioxp_defs.svh]
`ifndef IOXP_DEFS_SVH
`define IOXP_DEFS_SVH
// ==========================================
// register word offsets (byte addresses)
`define IOXP_A_INPUT 6'h00
`define IOXP_A_OUTPUT 6'h04
`define IOXP_A_DIR 6'h08
`define IOXP_A_LATCH 6'h0C
`define IOXP_A_PULLEN 6'h10
`define IOXP_A_PULLSEL 6'h14
`define IOXP_A_MASK 6'h18
`define IOXP_A_STATUS 6'h1C
`define IOXP_A_ODCFG 6'h20
// ==========================================
// reset values
`define IOXP_RST_ZERO 16'h0000
`define IOXP_RST_ONES 16'hFFFF
`define IOXP_RST_DIR 16'hFFFF
// ==========================================
// field positions
`define IOXP_OD_P0 0
`define IOXP_OD_P1 1
`define IOXP_PORT_W 8
`define IOXP_UNMAPPED 32'h0000_0000
`endif

// [core/ioxp_pkg.sv]
package ioxp_pkg;
    // bus slave states, one-hot
    typedef enum logic [1:0]
    {
        IOXP_IDLE = 2'b01,
        IOXP_RESP = 2'b10
    } ioxp_bus_type;
endpackage

// [core/ioxp_port.sv]
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ioxp_defs.svh"
module ioxp_port #(
    parameter int N = 16
) (
    input wire logic mclk, // 100 MHz clock
    input wire logic rstn, // async reset, active low
    input wire logic por_ok, // power-on detector: supply above por_threshold
    input wire logic reset_pin_n, // device reset pin, active low
    input wire logic [N-1:0] pin_in, // pad levels
    output logic [N-1:0] pin_out, // pad drive level
    output logic [N-1:0] pin_oe, // pad driver enable
    output logic [N-1:0] pull_up_en, // pull-up resistor connected
    output logic [N-1:0] pull_dn_en, // pull-down resistor connected
    output logic [N-1:0] in_buf_en, // input buffer enabled
    output logic irq_n_out, // interrupt pad output (always 0)
    output logic irq_n_oe, // interrupt pad enable, high pulls low
    input wire logic [5:0] address, // avalon byte address
    input wire logic read, // avalon read
    input wire logic write, // avalon write
    input wire logic [31:0] writedata, // avalon write data
    input wire logic [3:0] byteenable, // avalon byte enables
    output logic [31:0] readdata, // avalon read data
    output logic waitrequest // avalon wait
);
    localparam int PW = `IOXP_PORT_W;

    // ==========================================
    // reset gathering
    // internal reset: por and pin both must be high; reset pin is synchronised
    logic rp_s1;
    logic rp_s2;
    logic po_s1;
    logic po_s2;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rp_s1 <= 1'b0;
            rp_s2 <= 1'b0;
            po_s1 <= 1'b0;
            po_s2 <= 1'b0;
        end
        else
        begin
            rp_s1 <= reset_pin_n;
            rp_s2 <= rp_s1;
            po_s1 <= por_ok;
            po_s2 <= po_s1;
        end
    end
    // sync reset level; pulse width is the controller's duty
    logic soft_rst;
    assign soft_rst = !po_s2 || !rp_s2;

    // ==========================================
    // pin synchroniser, second stage only is used
    logic [N-1:0] pin_s1;
    logic [N-1:0] pin_s2;
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pin_s1 <= `IOXP_RST_ZERO;
            pin_s2 <= `IOXP_RST_ZERO;
        end
        else
        begin
            pin_s1 <= pin_in;
            pin_s2 <= pin_s1;
        end
    end

    // ==========================================
    // registers and interrupt state
    logic [N-1:0] outv, dir, latch_en, pull_en, pull_sel, mask;
    logic [1:0] od_cfg;
    logic [N-1:0] ref_val, pend, latched;
    logic [N-1:0] next_outv, next_dir, next_latch_en, next_pull_en, next_pull_sel, next_mask;
    logic [1:0] next_od_cfg;
    logic [N-1:0] next_ref_val, next_pend, next_latched;
    ioxp_pkg::ioxp_bus_type bstate, next_bstate;
    logic [31:0] next_readdata;

    logic [N-1:0] is_in;
    logic [N-1:0] in_view;
    logic [N-1:0] od_bits;
    logic take;
    logic [3:0] be;
    logic [N-1:0] wmask;
    logic [N-1:0] rd_clr;

    assign is_in = dir;
    assign od_bits = {{PW{od_cfg[`IOXP_OD_P1]}}, {PW{od_cfg[`IOXP_OD_P0]}}};
    // latched pins show the held value, others the live level
    assign in_view = (latch_en & latched) | (~latch_en & pin_s2);
    // requests are only taken out of reset, in idle
    assign take = (read || write) && bstate == ioxp_pkg::IOXP_IDLE && !soft_rst;
    assign be = byteenable;
    assign wmask = {{PW{be[1]}}, {PW{be[0]}}};

    // next-state for registers, bus and interrupt logic
    always_comb
    begin
        next_outv = outv;
        next_dir = dir;
        next_latch_en = latch_en;
        next_pull_en = pull_en;
        next_pull_sel = pull_sel;
        next_mask = mask;
        next_od_cfg = od_cfg;
        next_bstate = bstate;
        next_readdata = readdata;
        rd_clr = `IOXP_RST_ZERO;
        unique case (bstate)
            ioxp_pkg::IOXP_IDLE:
            begin
                if (take)
                begin
                    next_bstate = ioxp_pkg::IOXP_RESP;
                    next_readdata = `IOXP_UNMAPPED;
                    if (write)
                    begin
                        unique case (address)
                            `IOXP_A_OUTPUT: next_outv = (outv & ~wmask) | (writedata[N-1:0] & wmask);
                            `IOXP_A_DIR: next_dir = (dir & ~wmask) | (writedata[N-1:0] & wmask);
                            `IOXP_A_LATCH: next_latch_en = (latch_en & ~wmask) | (writedata[N-1:0] & wmask);
                            `IOXP_A_PULLEN: next_pull_en = (pull_en & ~wmask) | (writedata[N-1:0] & wmask);
                            `IOXP_A_PULLSEL: next_pull_sel = (pull_sel & ~wmask) | (writedata[N-1:0] & wmask);
                            `IOXP_A_MASK: next_mask = (mask & ~wmask) | (writedata[N-1:0] & wmask);
                            `IOXP_A_ODCFG:
                            begin
                                if (be[0])
                                begin
                                    next_od_cfg = writedata[1:0];
                                end
                            end
                            default: next_od_cfg = od_cfg;
                        endcase
                    end
                    else
                    begin
                        unique case (address)
                            `IOXP_A_INPUT:
                            begin
                                next_readdata = {16'h0000, in_view};
                                rd_clr = wmask;
                            end
                            `IOXP_A_OUTPUT: next_readdata = {16'h0000, outv};
                            `IOXP_A_DIR: next_readdata = {16'h0000, dir};
                            `IOXP_A_LATCH: next_readdata = {16'h0000, latch_en};
                            `IOXP_A_PULLEN: next_readdata = {16'h0000, pull_en};
                            `IOXP_A_PULLSEL: next_readdata = {16'h0000, pull_sel};
                            `IOXP_A_MASK: next_readdata = {16'h0000, mask};
                            `IOXP_A_STATUS: next_readdata = {16'h0000, pend & ~mask};
                            `IOXP_A_ODCFG: next_readdata = {30'h0000_0000, od_cfg};
                            default: next_readdata = `IOXP_UNMAPPED;
                        endcase
                    end
                end
            end
            ioxp_pkg::IOXP_RESP: next_bstate = ioxp_pkg::IOXP_IDLE;
        endcase

        // reference updates on read of the port; latched capture holds
        next_ref_val = ref_val;
        next_latched = latched;
        next_pend = pend;
        for (int i = 0; i < N; i++)
        begin
            if (!is_in[i])
            begin
                // outputs neither capture nor flag; ref left stale on purpose
                next_pend[i] = 1'b0;
                next_latched[i] = pin_s2[i];
            end
            else
            begin
                if (rd_clr[i])
                begin
                    // restart from the live level, else a reverted latch flags the same edge twice
                    next_ref_val[i] = pin_s2[i];
                    next_latched[i] = pin_s2[i];
                    next_pend[i] = 1'b0;
                end
                if (latch_en[i])
                begin
                    // capture first change, hold it until read
                    if (pin_s2[i] != ref_val[i] && !pend[i])
                    begin
                        next_latched[i] = pin_s2[i];
                        next_pend[i] = 1'b1;
                    end
                end
                else
                begin
                    next_latched[i] = pin_s2[i];
                    // edge vs reference; read clear wins over set
                    // a stale ref after output-to-input gives a false flag
                    if (pin_s2[i] != ref_val[i] && !rd_clr[i])
                    begin
                        next_pend[i] = 1'b1;
                    end
                    else if (pin_s2[i] == ref_val[i])
                    begin
                        next_pend[i] = 1'b0;
                    end
                end
            end
        end
    end

    // register stage; sync soft reset loads defaults, but ref and latched take the live pin level
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            outv <= `IOXP_RST_ONES;
            dir <= `IOXP_RST_DIR;
            latch_en <= `IOXP_RST_ZERO;
            pull_en <= `IOXP_RST_ZERO;
            pull_sel <= `IOXP_RST_ONES;
            mask <= `IOXP_RST_ONES;
            od_cfg <= 2'b00;
            ref_val <= `IOXP_RST_ZERO;
            latched <= `IOXP_RST_ZERO;
            pend <= `IOXP_RST_ZERO;
            bstate <= ioxp_pkg::IOXP_IDLE;
            readdata <= `IOXP_UNMAPPED;
        end
        else if (soft_rst)
        begin
            outv <= `IOXP_RST_ONES;
            dir <= `IOXP_RST_DIR;
            latch_en <= `IOXP_RST_ZERO;
            pull_en <= `IOXP_RST_ZERO;
            pull_sel <= `IOXP_RST_ONES;
            mask <= `IOXP_RST_ONES;
            od_cfg <= 2'b00;
            ref_val <= pin_s2;
            latched <= pin_s2;
            pend <= `IOXP_RST_ZERO;
            bstate <= ioxp_pkg::IOXP_IDLE;
            readdata <= `IOXP_UNMAPPED;
        end
        else
        begin
            outv <= next_outv;
            dir <= next_dir;
            latch_en <= next_latch_en;
            pull_en <= next_pull_en;
            pull_sel <= next_pull_sel;
            mask <= next_mask;
            od_cfg <= next_od_cfg;
            ref_val <= next_ref_val;
            latched <= next_latched;
            pend <= next_pend;
            bstate <= next_bstate;
            readdata <= next_readdata;
        end
    end

    // wait until the response cycle; refused requests stall
    assign waitrequest = bstate != ioxp_pkg::IOXP_RESP;

    // ==========================================
    // pad stage
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            // open-drain output only drives low
            pin_out[i] = outv[i];
            pin_oe[i] = !is_in[i] && !(od_bits[i] && outv[i]);
            in_buf_en[i] = is_in[i];
            pull_up_en[i] = pull_en[i] && !od_bits[i] && pull_sel[i];
            pull_dn_en[i] = pull_en[i] && !od_bits[i] && !pull_sel[i];
        end
    end

    // unmasked pending pins pull the interrupt line low
    assign irq_n_out = 1'b0;
    assign irq_n_oe = |(pend & ~mask);
endmodule
`default_nettype wire

// [bench/ioxp_port_properties.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// pad, reset, interrupt and bus wait checks
module ioxp_chk #(
    parameter int N = 16
) (
    input wire logic mclk, // clock
    input wire logic rstn, // async reset, active low
    input wire logic por_ok, // supply good
    input wire logic reset_pin_n, // reset pin, active low
    input wire logic [N-1:0] pin_oe, // driver enable
    input wire logic [N-1:0] pull_up_en, // pull-up on
    input wire logic [N-1:0] pull_dn_en, // pull-down on
    input wire logic [N-1:0] in_buf_en, // input buffer on
    input wire logic irq_n_out, // interrupt level
    input wire logic irq_n_oe, // interrupt pull
    input wire logic waitrequest // bus wait
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // sync reset needs two edges, so allow four before judging
    // an open-drain output at one has neither on, so only both-on is illegal
    AST_BUF_OFF: assert property ((in_buf_en & pin_oe) == '0) else $error("buffer and driver both on");
    AST_IRQ_LOW: assert property (irq_n_out == 1'b0) else $error("interrupt pad drives high");
    AST_PULL_ONE: assert property ((pull_up_en & pull_dn_en) == '0) else $error("both pulls on");
    AST_RST_STALL: assert property (!reset_pin_n [*4] |-> waitrequest) else $error("access in reset");
    AST_RST_DEF: assert property (!reset_pin_n [*4] |-> pin_oe == '0 && !irq_n_oe && pull_up_en == '0)
        else $error("reset pin left state");
    AST_POR_HOLD: assert property (!por_ok [*4] |-> waitrequest && pin_oe == '0) else $error("por not held");
    AST_OUT_QUIET: assert property (pin_oe == '1 [*4] |-> !irq_n_oe) else $error("output pin raised irq");
    AST_WAIT_ONE: assert property (!waitrequest |=> waitrequest) else $error("answer longer than one cycle");
endmodule
bind ioxp_port ioxp_chk #(.N(N)) i_chk (.mclk, .rstn, .por_ok, .reset_pin_n, .pin_oe, .pull_up_en, .pull_dn_en,
    .in_buf_en, .irq_n_out, .irq_n_oe, .waitrequest);
`default_nettype wire

// [bench/ioxp_pad_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// pads as seen from the board
module ioxp_pad_model #(
    parameter int N = 16
) (
    input wire logic mclk, // clock for floating noise
    input wire logic [N-1:0] pin_out, // device drive level
    input wire logic [N-1:0] pin_oe, // device drive enable
    input wire logic [N-1:0] pull_up_en, // device pull-up
    input wire logic [N-1:0] pull_dn_en, // device pull-down
    input wire logic [N-1:0] ext_en, // board source drives
    input wire logic [N-1:0] ext_val, // board source level
    output logic [N-1:0] pin_in // resolved pad level
);
    logic noise = 1'b0;
    // a floating pad wanders, so a stale level is never read back
    always_ff @(posedge mclk) noise <= ~noise;
    // device driver first, then board source, then pull resistor
    always_comb
    begin
        for (int i = 0; i < N; i++)
        begin
            if (pin_oe[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pull_up_en[i] || pull_dn_en[i]) pin_in[i] = pull_up_en[i];
            else pin_in[i] = noise;
        end
    end
endmodule
`default_nettype wire

// [bench/ioxp_port_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module ioxp_port_tb;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic por_ok = 1'b1;
    logic reset_pin_n = 1'b1;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [5:0] address = 6'h00;
    logic [31:0] writedata = 32'h0;
    logic [3:0] byteenable = 4'hF;
    logic [15:0] ext_en = 16'hFFFF;
    logic [15:0] ext_val = 16'h0;
    logic [15:0] pin_in, pin_out, pin_oe, pull_up_en, pull_dn_en, in_buf_en;
    logic irq_n_out, irq_n_oe, waitrequest;
    logic [31:0] readdata, q;
    logic [31:0] dflt [10] = '{32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0, 32'hFFFF, 32'hFFFF, 32'h0, 32'h0, 32'h0};
    int fail_count = 0;
    int compares = 0;
    ioxp_port i_dut (.mclk, .rstn, .por_ok, .reset_pin_n, .pin_in, .pin_out, .pin_oe, .pull_up_en, .pull_dn_en,
        .in_buf_en, .irq_n_out, .irq_n_oe, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest);
    ioxp_pad_model i_pad (.mclk, .pin_out, .pin_oe, .pull_up_en, .pull_dn_en, .ext_en, .ext_val, .pin_in);
    // ==========================================
    // helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // one transfer; leading edge keeps back-to-back calls from double driving
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        address <= a;
        writedata <= d;
        write <= wr;
        read <= !wr;
        // request stands until the rising edge that sees waitrequest low
        do
        begin
            @(posedge mclk);
            n++;
        end
        while (waitrequest !== 1'b0 && n < 100);
        if (waitrequest !== 1'b0)
        begin
            fail_count++;
            stop_test();
        end
        else
        begin
            q = readdata;
            read <= 1'b0;
            write <= 1'b0;
        end
    endtask
    // irq needs two sync edges plus one, six is ample
    task automatic irq_is(input logic e);
        repeat (6) @(negedge mclk);
        check("irq pull", irq_n_oe, e);
    endtask
    task automatic pin_set(input int b, input logic v, input logic e);
        @(posedge mclk);
        ext_val[b] <= v;
        irq_is(e);
    endtask
    // ==========================================
    // clock and sequence
    initial
    begin
        forever #5 mclk = ~mclk;
    end
    initial
    begin
        repeat (3) @(posedge mclk);
        rstn <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 10; i++)
        begin
            bus(1'b0, 6'(i * 4), 32'h0);
            check("reset value", q, dflt[i]);
        end
        $display("test defaults done");
        bus(1'b1, 6'h04, 32'h00A5);
        bus(1'b1, 6'h18, 32'h0);
        bus(1'b1, 6'h08, 32'h0);
        bus(1'b1, 6'h04, 32'h005A);
        irq_is(1'b0);
        bus(1'b1, 6'h08, 32'hFF00);
        bus(1'b0, 6'h00, 32'h0);
        @(negedge mclk);
        check("drive enable", pin_oe, 32'h00FF);
        check("drive level", pin_out[7:0], 32'h5A);
        check("input buffer", in_buf_en, 32'hFF00);
        $display("test outputs done");
        pin_set(8, 1'b1, 1'b1);
        bus(1'b0, 6'h1C, 32'h0);
        check("status", q, 32'h0100);
        pin_set(8, 1'b0, 1'b0);
        pin_set(9, 1'b1, 1'b1);
        bus(1'b0, 6'h00, 32'h0);
        check("input high byte", q[15:8], 32'h02);
        irq_is(1'b0);
        pin_set(9, 1'b0, 1'b1);
        bus(1'b0, 6'h00, 32'h0);
        irq_is(1'b0);
        $display("test edges done");
        bus(1'b1, 6'h18, 32'hFFFF);
        pin_set(10, 1'b1, 1'b0);
        bus(1'b1, 6'h18, 32'h0);
        irq_is(1'b1);
        bus(1'b0, 6'h00, 32'h0);
        bus(1'b1, 6'h0C, 32'h0800);
        pin_set(11, 1'b1, 1'b1);
        pin_set(11, 1'b0, 1'b1);
        bus(1'b0, 6'h00, 32'h0);
        check("latched bit", q[11], 32'h1);
        irq_is(1'b0);
        bus(1'b0, 6'h00, 32'h0);
        check("latched bit next", q[11], 32'h0);
        $display("test mask and latch done");
        bus(1'b1, 6'h10, 32'h1000);
        ext_en <= 16'hEFFF;
        // pulled level needs both sync stages before the read takes it
        repeat (3) @(negedge mclk);
        check("pull up", pull_up_en, 32'h1000);
        check("pull down", pull_dn_en, 32'h0);
        bus(1'b0, 6'h00, 32'h0);
        check("pulled pad", q[12], 32'h1);
        bus(1'b1, 6'h14, 32'h0);
        @(negedge mclk);
        check("pull down sel", pull_dn_en, 32'h1000);
        bus(1'b1, 6'h20, 32'h2);
        @(negedge mclk);
        check("pull open drain", pull_dn_en, 32'h0);
        ext_en <= 16'hFFFF;
        $display("test pulls done");
        bus(1'b1, 6'h18, 32'h1234);
        reset_pin_n <= 1'b0;
        repeat (8) @(posedge mclk);
        reset_pin_n <= 1'b1;
        repeat (4) @(posedge mclk);
        bus(1'b0, 6'h18, 32'h0);
        check("mask after reset pin", q, 32'hFFFF);
        bus(1'b1, 6'h0C, 32'h00FF);
        por_ok <= 1'b0;
        repeat (8) @(posedge mclk);
        por_ok <= 1'b1;
        repeat (4) @(posedge mclk);
        bus(1'b0, 6'h0C, 32'h0);
        check("latch after por", q, 32'h0);
        $display("test resets done");
        stop_test();
    end
endmodule
`default_nettype wire
